// ==== sst_pkg.sv ====
/*
  Package for the synchronous serial transmit framing block: register offsets,
  field layouts, reset values, status bit positions and state encodings.
  Assumes a single clock domain for the register side.
*/
`default_nettype none

package sst_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on the register bus)
  // ****************************************************************
  localparam logic [5:0] OFS_FMR = 6'h00;
  localparam logic [5:0] OFS_RHR = 6'h04;
  localparam logic [5:0] OFS_THR = 6'h08;
  localparam logic [5:0] OFS_RSH = 6'h0c;
  localparam logic [5:0] OFS_TSH = 6'h10;
  localparam logic [5:0] OFS_CP0 = 6'h14;
  localparam logic [5:0] OFS_CP1 = 6'h18;
  localparam logic [5:0] OFS_SR = 6'h1c;
  localparam logic [5:0] OFS_CTL = 6'h20;

  // ****************************************************************
  // Field layouts and reset values
  // ****************************************************************
  typedef struct packed {
    logic [6:0] rsv_hi;
    logic sync_edge_select;
    logic sync_data_output_enable;
    logic [2:0] sync_output_shape;
    logic [3:0] sync_length;
    logic [3:0] rsv_mid;
    logic [3:0] words_per_frame;
    logic bit_order_select;
    logic rsv_lo;
    logic idle_line_level;
    logic [4:0] word_length_field;
  } sst_fmr_t;

  typedef struct packed {
    logic [23:0] rsv;
    logic [3:0] sync_length_extension;
    logic rsv3;
    logic open_drain;
    logic receiver_on;
    logic transmitter_on;
  } sst_ctl_t;

  localparam logic [31:0] FMR_WMASK = 32'h01ff_0fbf;
  localparam logic [31:0] CTL_WMASK = 32'h0000_00f7;
  localparam logic [31:0] FMR_RST = 32'h0000_0000;
  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [15:0] HALF_RST = 16'h0000;

  // ****************************************************************
  // Status bit positions
  // ****************************************************************
  localparam int SR_TX_HOLDING_FREE = 0;
  localparam int SR_TX_ALL_SENT = 1;
  localparam int SR_RX_WORD_AVAILABLE = 4;
  localparam int SR_OVR = 5;
  localparam int SR_CP0 = 8;
  localparam int SR_CP1 = 9;
  localparam int SR_TX_SYNC_EVENT = 10;
  localparam int SR_RX_SYNC_EVENT = 11;
  localparam int SR_TRANSMITTER_ON = 16;
  localparam int SR_RECEIVER_ON = 17;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] DMA_BYTE = 2'h0;
  localparam logic [1:0] DMA_HALF = 2'h1;
  localparam logic [1:0] DMA_WORD = 2'h2;
  localparam logic [4:0] LEN_BYTE_MAX = 5'h07;
  localparam logic [4:0] LEN_HALF_MAX = 5'h0f;

  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_DATA} sst_tx_t;

endpackage

`default_nettype wire

// ==== sst_top.sv ====
/*
  Transmit framing, holding registers and status of a synchronous serial
  controller, reached over AXI4-Lite. Assumes the link clock, frame syncs and
  receive data arrive asynchronously and are far slower than i_clock.
*/
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`default_nettype none

// Functional notes
// - Each word serializes word length field plus one bits.
// - DMA size: bytes up to 7, half-words 8 to 15, else words.
// - Data line sits at the idle level whenever no transmission runs.
// - In open-drain mode the data driver is on only while data is 1.
// - Bit order 0 sends LSB first, 1 sends MSB first.
// - Each transfer start sends words per frame plus one words, or fewer if the holding register is empty at a word end.
// - Sync length sets sync duration and count of sync data bits sent.
// - Sync pulse lasts sync length plus one link periods, extension on top.
// - Sync shape codes: input, neg, pos, low, high, toggle; 6-7 reserved.
// - During sync the data line carries idle level or sync word bits.
// - Transmit sync flag on rising edge for select 0, falling for 1.
// - Holding words right aligned; receive read-only, transmit write-only.
// - Transmit sync holding is a 16-bit read-write value.
// - Receive sync holding is a read-only 16-bit captured value.
// - Two compare registers hold 16-bit read-write patterns.
// - Holding-free reads 1 when the transmit holding register is empty.
// - All-sent reads 1 only after the last word fully left.
// - Overwrite sets on load over an unread word, clears on status read.
// - Compare and sync flags record events, clear on status read.

module sst_top
  import sst_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [5:0] i_axi_awaddr,
  input wire logic i_axi_awvalid,
  output logic o_axi_awready,
  input wire logic [31:0] i_axi_wdata,
  input wire logic [3:0] i_axi_wstrb,
  input wire logic i_axi_wvalid,
  output logic o_axi_wready,
  output logic [1:0] o_axi_bresp,
  output logic o_axi_bvalid,
  input wire logic i_axi_bready,
  input wire logic [5:0] i_axi_araddr,
  input wire logic i_axi_arvalid,
  output logic o_axi_arready,
  output logic [31:0] o_axi_rdata,
  output logic [1:0] o_axi_rresp,
  output logic o_axi_rvalid,
  input wire logic i_axi_rready,
  input wire logic i_tx_clock,
  input wire logic i_tx_frame_sync_pin,
  input wire logic i_serial_in,
  input wire logic i_rx_frame_sync,
  output logic o_serial_out_pin,
  output logic o_serial_out_pin_oe,
  output logic o_tx_frame_sync_pin,
  output logic o_tx_frame_sync_pin_oe,
  output logic [1:0] o_dma_size
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic awv;
    logic [5:0] awa;
    logic wv;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awr;
    logic wr;
    logic bv;
    logic [1:0] br;
    logic arr;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
    sst_fmr_t fmr;
    sst_ctl_t ctl;
    logic [31:0] thr;
    logic thr_full;
    logic [15:0] tsh;
    logic [15:0] rsh;
    logic [15:0] cp0;
    logic [15:0] cp1;
    logic [31:0] rhr;
    logic rx_word_available;
    logic ovr;
    logic c0;
    logic c1;
    logic txs;
    logic rxs;
    logic [2:0] cks;
    logic [1:0] tfs;
    logic [1:0] rds;
    logic [1:0] rfs;
    logic fsp;
    logic rfp;
    sst_tx_t st;
    logic [31:0] tsr;
    logic [7:0] idx;
    logic [3:0] wcnt;
    logic tog;
    logic so;
    logic soe;
    logic fso;
    logic fsoe;
    logic [1:0] dsz;
    logic [31:0] rsr;
    logic [4:0] rbc;
  } sst_st_t;

  sst_st_t st_q;
  sst_st_t st_d;
  logic [1:0] rst_q;
  logic rst_n;
  logic wr_thr;
  logic rx_load;
  logic ck_f;
  logic [31:0] sts_now;

  // Reset is released through two flops so all state leaves reset together.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic logic mapped(logic [5:0] a);
    return a inside {OFS_FMR, OFS_RHR, OFS_THR, OFS_RSH, OFS_TSH,
                     OFS_CP0, OFS_CP1, OFS_SR, OFS_CTL};
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] sts_word(sst_st_t s);
    logic [31:0] w;
    w = 32'h0;
    w[SR_TX_HOLDING_FREE] = !s.thr_full;
    w[SR_TX_ALL_SENT] = !s.thr_full && (s.st == TX_IDLE);
    w[SR_RX_WORD_AVAILABLE] = s.rx_word_available;
    w[SR_OVR] = s.ovr;
    w[SR_CP0] = s.c0;
    w[SR_CP1] = s.c1;
    w[SR_TX_SYNC_EVENT] = s.txs;
    w[SR_RX_SYNC_EVENT] = s.rxs;
    w[SR_TRANSMITTER_ON] = s.ctl.transmitter_on;
    w[SR_RECEIVER_ON] = s.ctl.receiver_on;
    return w;
  endfunction

  function automatic logic [31:0] rd_mux(sst_st_t s, logic [5:0] a);
    case (a)
      OFS_FMR: return s.fmr;
      OFS_RHR: return s.rhr;
      OFS_RSH: return {16'h0, s.rsh};
      OFS_TSH: return {16'h0, s.tsh};
      OFS_CP0: return {16'h0, s.cp0};
      OFS_CP1: return {16'h0, s.cp1};
      OFS_SR: return sts_word(s);
      OFS_CTL: return s.ctl;
      default: return 32'h0;
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic ld;
    logic ck_r;
    logic fs_now;
    logic bit_in;
    logic rd_rhr;
    logic [7:0] slen;
    logic [4:0] bi;
    ld = 1'b0;
    bi = 5'h0;
    ck_r = st_q.cks[1] & ~st_q.cks[2];
    ck_f = ~st_q.cks[1] & st_q.cks[2];
    fs_now = st_q.fsoe ? st_q.fso : st_q.tfs[1];
    bit_in = st_q.rds[1];
    rd_rhr = 1'b0;
    rx_load = 1'b0;
    slen = {st_q.ctl.sync_length_extension, st_q.fmr.sync_length};
    st_d = st_q;
    wr_thr = st_q.awv && st_q.wv && (st_q.awa == OFS_THR);

    // Bus read side; flag clears come first so that later sets win.
    if (st_q.rv && i_axi_rready) begin
      st_d.rv = 1'b0;
    end
    if (i_axi_arvalid && st_q.arr) begin
      st_d.rv = 1'b1;
      st_d.rd = rd_mux(st_q, i_axi_araddr);
      st_d.rr = mapped(i_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (i_axi_araddr == OFS_SR) begin
        st_d.ovr = 1'b0;
        st_d.c0 = 1'b0;
        st_d.c1 = 1'b0;
        st_d.txs = 1'b0;
        st_d.rxs = 1'b0;
      end
      if (i_axi_araddr == OFS_RHR) begin
        rd_rhr = 1'b1;
        st_d.rx_word_available = 1'b0;
      end
    end

    // Link inputs pass two flops; the link clock's third stage holds its previous level.
    st_d.cks = {st_q.cks[1:0], i_tx_clock};
    st_d.tfs = {st_q.tfs[0], i_tx_frame_sync_pin};
    st_d.rds = {st_q.rds[0], i_serial_in};
    st_d.rfs = {st_q.rfs[0], i_rx_frame_sync};

    // Transmitter advances on the falling link edge.
    if (ck_f) begin
      case (st_q.st)
        TX_IDLE: begin
          if (st_q.ctl.transmitter_on && st_q.thr_full) begin
            ld = 1'b1;
            st_d.wcnt = 4'h0;
            st_d.idx = 8'h0;
            st_d.tog = ~st_q.tog;
            st_d.st = (st_q.fmr.sync_output_shape == 3'h0) ? TX_DATA : TX_SYNC;
          end
        end
        TX_SYNC: begin
          if (st_q.idx == slen) begin
            st_d.st = TX_DATA;
            st_d.idx = 8'h0;
          end else begin
            st_d.idx = st_q.idx + 8'h01;
          end
        end
        TX_DATA: begin
          if (st_q.idx[4:0] == st_q.fmr.word_length_field) begin
            if (st_q.wcnt == st_q.fmr.words_per_frame) begin
              st_d.st = TX_IDLE;
            end else if (st_q.thr_full) begin
              ld = 1'b1;
              st_d.wcnt = st_q.wcnt + 4'h1;
              st_d.idx = 8'h0;
            end else begin
              // An empty holding register cuts the frame short.
              st_d.st = TX_IDLE;
            end
          end else begin
            st_d.idx = st_q.idx + 8'h01;
          end
        end
        default: begin
          st_d.st = TX_IDLE;
        end
      endcase
    end
    if (ld) begin
      st_d.tsr = st_q.thr;
      st_d.thr_full = 1'b0;
    end

    // Transmit sync event from the sync line, driven or sensed.
    st_d.fsp = fs_now;
    if (st_q.fmr.sync_edge_select ? (st_q.fsp && !fs_now) : (!st_q.fsp && fs_now)) begin
      st_d.txs = 1'b1;
    end

    // Receiver samples on the rising link edge, MSB first.
    if (ck_r && st_q.ctl.receiver_on) begin
      st_d.rfp = st_q.rfs[1];
      if (st_q.rfs[1]) begin
        st_d.rsh = st_q.rfp ? {st_q.rsh[14:0], bit_in} : {15'h0, bit_in};
        st_d.rbc = 5'h0;
        st_d.rsr = 32'h0;
      end else begin
        if (st_q.rfp) begin
          st_d.rxs = 1'b1;
          st_d.c0 = st_q.c0 | (st_q.rsh == st_q.cp0);
          st_d.c1 = st_q.c1 | (st_q.rsh == st_q.cp1);
        end
        st_d.rsr = {st_q.rsr[30:0], bit_in};
        st_d.rbc = st_q.rbc + 5'h01;
        if (st_q.rbc == st_q.fmr.word_length_field) begin
          rx_load = 1'b1;
          st_d.rhr = {st_q.rsr[30:0], bit_in};
          st_d.rsr = 32'h0;
          st_d.rbc = 5'h0;
          st_d.rx_word_available = 1'b1;
          if (st_q.rx_word_available && !rd_rhr) begin
            st_d.ovr = 1'b1;
          end
        end
      end
    end

    // Bus write side; taken after the transmitter so a new word is kept.
    if (i_axi_awvalid && st_q.awr) begin
      st_d.awv = 1'b1;
      st_d.awa = i_axi_awaddr;
    end
    if (i_axi_wvalid && st_q.wr) begin
      st_d.wv = 1'b1;
      st_d.wd = i_axi_wdata;
      st_d.ws = i_axi_wstrb;
    end
    if (st_q.bv && i_axi_bready) begin
      st_d.bv = 1'b0;
    end
    if (st_q.awv && st_q.wv) begin
      st_d.awv = 1'b0;
      st_d.wv = 1'b0;
      st_d.bv = 1'b1;
      st_d.br = mapped(st_q.awa) ? RESP_OKAY : RESP_SLVERR;
      case (st_q.awa)
        OFS_FMR: st_d.fmr = merge(st_q.fmr, st_q.wd, st_q.ws) & FMR_WMASK;
        OFS_CTL: st_d.ctl = merge(st_q.ctl, st_q.wd, st_q.ws) & CTL_WMASK;
        OFS_TSH: st_d.tsh = 16'(merge({16'h0, st_q.tsh}, st_q.wd, st_q.ws));
        OFS_CP0: st_d.cp0 = 16'(merge({16'h0, st_q.cp0}, st_q.wd, st_q.ws));
        OFS_CP1: st_d.cp1 = 16'(merge({16'h0, st_q.cp1}, st_q.wd, st_q.ws));
        OFS_THR: begin
          st_d.thr = merge(st_q.thr, st_q.wd, st_q.ws);
          st_d.thr_full = 1'b1;
        end
        default: begin
        end
      endcase
    end
    st_d.awr = !st_d.awv && !st_d.bv;
    st_d.wr = !st_d.wv && !st_d.bv;
    st_d.arr = !st_d.rv;

    // Pin levels are recomputed every cycle so idle follows the register.
    bi = st_d.fmr.bit_order_select ?
         5'(st_d.fmr.word_length_field - st_d.idx[4:0]) : st_d.idx[4:0];
    case (st_d.st)
      TX_SYNC: begin
        st_d.so = (st_d.fmr.sync_data_output_enable && st_d.idx[7:4] == 4'h0) ?
                  st_d.tsh[st_d.idx[3:0]] : st_d.fmr.idle_line_level;
      end
      TX_DATA: st_d.so = st_d.tsr[bi];
      default: st_d.so = st_d.fmr.idle_line_level;
    endcase
    st_d.soe = st_d.ctl.open_drain ? st_d.so : 1'b1;
    case (st_d.fmr.sync_output_shape)
      3'h1: st_d.fso = st_d.st != TX_SYNC;
      3'h2: st_d.fso = st_d.st == TX_SYNC;
      3'h3: st_d.fso = st_d.st == TX_IDLE;
      3'h4: st_d.fso = st_d.st != TX_IDLE;
      3'h5: st_d.fso = st_d.tog;
      default: st_d.fso = 1'b0;
    endcase
    // Reserved shapes leave the pin undriven, like the input-only code.
    st_d.fsoe = st_d.fmr.sync_output_shape inside {[3'h1 : 3'h5]};
    if (st_d.fmr.word_length_field <= LEN_BYTE_MAX) begin
      st_d.dsz = DMA_BYTE;
    end else if (st_d.fmr.word_length_field <= LEN_HALF_MAX) begin
      st_d.dsz = DMA_HALF;
    end else begin
      st_d.dsz = DMA_WORD;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.fmr <= FMR_RST;
      st_q.ctl <= CTL_RST;
      st_q.tsh <= HALF_RST;
      st_q.st <= TX_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_axi_awready = st_q.awr;
  assign o_axi_wready = st_q.wr;
  assign o_axi_bvalid = st_q.bv;
  assign o_axi_bresp = st_q.br;
  assign o_axi_arready = st_q.arr;
  assign o_axi_rvalid = st_q.rv;
  assign o_axi_rdata = st_q.rd;
  assign o_axi_rresp = st_q.rr;
  assign o_serial_out_pin = st_q.so;
  assign o_serial_out_pin_oe = st_q.soe;
  assign o_tx_frame_sync_pin = st_q.fso;
  assign o_tx_frame_sync_pin_oe = st_q.fsoe;
  assign o_dma_size = st_q.dsz;
  assign sts_now = sts_word(st_q);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    ck_f && st_q.st == TX_IDLE && st_q.ctl.transmitter_on && st_q.thr_full && !wr_thr;
  endsequence
  sequence s_busy;
    st_q.st != TX_IDLE && !st_q.thr_full;
  endsequence

  property p_start;
    s_start |=> s_busy;
  endproperty
  a_start: assert property (p_start) else $error("frame did not start");

  property p_idle;
    st_q.st == TX_IDLE |-> st_q.so == st_q.fmr.idle_line_level;
  endproperty
  a_idle: assert property (p_idle) else $error("idle level wrong");

  property p_od;
    st_q.ctl.open_drain |-> st_q.soe == st_q.so;
  endproperty
  a_od: assert property (p_od) else $error("open drain enable wrong");

  property p_dma;
    st_q.fmr.word_length_field <= LEN_BYTE_MAX |-> st_q.dsz == DMA_BYTE;
  endproperty
  a_dma: assert property (p_dma) else $error("dma size wrong");

  property p_thr;
    wr_thr |=> !sts_now[SR_TX_HOLDING_FREE];
  endproperty
  a_thr: assert property (p_thr) else $error("holding free after write");

  property p_empty;
    st_q.st != TX_IDLE |-> !sts_now[SR_TX_ALL_SENT];
  endproperty
  a_empty: assert property (p_empty) else $error("all sent while busy");

  property p_ovr;
    rx_load && st_q.rx_word_available && !(i_axi_arvalid && st_q.arr) |=> st_q.ovr;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overwrite missed");

  property p_clr;
    i_axi_arvalid && st_q.arr && i_axi_araddr == OFS_SR && !st_q.rfp |=> !st_q.c0;
  endproperty
  a_clr: assert property (p_clr) else $error("compare flag not cleared");

  property p_pulse;
    st_q.st == TX_SYNC && st_q.fmr.sync_output_shape == 3'h2 |-> st_q.fso && st_q.fsoe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("positive pulse wrong");

  property p_sync;
    st_q.fmr.sync_edge_select == 1'b0 && !st_q.fsoe && !st_q.fsp && st_q.tfs[1]
      |=> st_q.txs;
  endproperty
  a_sync: assert property (p_sync) else $error("sync flag missed");

endmodule // sst_top

`default_nettype wire

// ==== sst_far_end.sv ====
/*
  Far-end serial partner: makes the link clock only while asked to, and records
  the transmit data and frame-sync pins at every falling link edge, and loops
  both back to the receive inputs.
  Assumes the bench reads the two queues after each frame.
*/
`default_nettype none

module sst_far_end (
  input wire logic i_run,
  input wire logic i_data,
  input wire logic i_sync,
  output logic o_link_clock,
  output logic o_rx_data,
  output logic o_rx_sync
);
  timeunit 1ns;
  timeprecision 1ns;

  logic data_q[$];
  logic sync_q[$];

  assign o_rx_data = i_data;
  assign o_rx_sync = i_sync;

  // ****************************************************************
  // Link clock and capture
  // ****************************************************************
  // The clock parks low between frames, as a codec would stop it.
  initial begin
    o_link_clock = 1'b0;
    #37;
    forever begin
      #200;
      if (i_run || o_link_clock) begin
        o_link_clock = ~o_link_clock;
      end
    end
  end

  // Sampling on the falling edge sees the bit launched one period earlier,
  // well clear of the device's own edge-detect delay.
  always @(negedge o_link_clock) begin
    data_q.push_back(i_data);
    sync_q.push_back(i_sync);
  end
endmodule // sst_far_end

`default_nettype wire

// ==== tb_sync_serial_tx_framing_and_data.sv ====
/*
  Self-checking bench for the transmit framing block: AXI4-Lite register
  tasks, frame capture through the far-end model. Assumes sst_pkg is compiled.
*/
`default_nettype none

module tb_sync_serial_tx_framing_and_data
  import sst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready, run;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, dma_size;
  logic sd, sd_oe, fs, fs_oe, lclk, rxd, rxs;
  logic [31:0] seen;
  logic [5:0] regs[3] = '{OFS_TSH, OFS_CP0, OFS_CP1};
  logic [4:0] lens[6] = '{5'h01, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h1f};
  int err_total = 0;
  int compares = 0;

  always #25 clock = ~clock;

  sst_top DUT (.i_clock(clock), .i_nrst(nrst), .i_axi_awaddr(awaddr),
    .i_axi_awvalid(awvalid), .o_axi_awready(awready), .i_axi_wdata(wdata),
    .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
    .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
    .i_axi_araddr(araddr), .i_axi_arvalid(arvalid), .o_axi_arready(arready),
    .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
    .i_axi_rready(rready), .i_tx_clock(lclk), .i_tx_frame_sync_pin(1'b0),
    .i_serial_in(rxd), .i_rx_frame_sync(rxs), .o_serial_out_pin(sd),
    .o_serial_out_pin_oe(sd_oe), .o_tx_frame_sync_pin(fs),
    .o_tx_frame_sync_pin_oe(fs_oe), .o_dma_size(dma_size));

  sst_far_end u_far (.i_run(run), .i_data(sd), .i_sync(fs), .o_link_clock(lclk),
    .o_rx_data(rxd), .o_rx_sync(rxs));

  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 100) begin
      err_total++;
      tally_and_finish();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 100) begin
      err_total++;
      tally_and_finish();
    end
    d = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // Polls status until bit b is set; every event bit seen on the way is kept.
  task automatic wait_sr(input int b);
    logic [31:0] s;
    int n;
    for (n = 0; n < 2000; n++) begin
      rd(OFS_SR, s, RESP_OKAY);
      seen |= s;
      if (s[b]) break;
    end
    if (n == 2000) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // ****************************************************************
  // Frame scenario: sync phase of 4 periods, then two words, then idle
  // ****************************************************************
  task automatic frame(input logic [4:0] dl, input logic msb, input logic [2:0] shp,
                       input logic fsd, input logic esel);
    logic [31:0] s;
    logic [63:0] ww;
    logic [15:0] tsh;
    logic act, e;
    int i0, k, b, wd;
    ww = 64'hfedc_9b3e_1234_5a6c;
    tsh = 16'hc3a5;
    act = (shp == 3'h2);
    wr(OFS_FMR, {7'h0, esel, fsd, shp, 4'h3, 4'h0, 4'h1, msb, 2'b01, dl}, RESP_OKAY);
    wr(OFS_TSH, {16'h0, tsh}, RESP_OKAY);
    u_far.data_q.delete();
    u_far.sync_q.delete();
    wr(OFS_THR, ww[31:0], RESP_OKAY);
    rd(OFS_SR, s, RESP_OKAY);
    chk({30'h0, s[1:0]}, 32'h0);
    seen = 32'h0;
    run <= 1'b1;
    wait_sr(SR_TX_HOLDING_FREE);
    wr(OFS_THR, ww[63:32], RESP_OKAY);
    wait_sr(SR_TX_ALL_SENT);
    repeat (24) @(posedge clock);
    run <= 1'b0;
    chk(seen[SR_TX_SYNC_EVENT], 1'b1);
    rd(OFS_SR, s, RESP_OKAY);
    chk(s[SR_TX_SYNC_EVENT], 1'b0);
    // A positive pulse frames the looped-back sync bits, received MSB first.
    if (shp == 3'h2) begin
      chk(seen[SR_RX_SYNC_EVENT], 1'b1);
      chk(seen[SR_CP0], 1'b1);
      rd(OFS_RSH, s, RESP_OKAY);
      chk(s, {28'h0, tsh[0], tsh[1], tsh[2], tsh[3]});
    end
    for (i0 = 1; i0 < u_far.sync_q.size(); i0++) begin
      if (u_far.sync_q[i0] !== u_far.sync_q[0]) break;
    end
    chk(u_far.sync_q[0], !act);
    for (k = 0; k < 4; k++) begin
      chk(u_far.sync_q[i0 + k], act);
      chk(u_far.data_q[i0 + k], fsd ? tsh[k] : 1'b1);
    end
    chk(u_far.sync_q[i0 + 4], !act);
    for (k = 0; k <= 2 * (dl + 1); k++) begin
      b = k % (dl + 1);
      wd = k / (dl + 1);
      e = (wd == 2) ? 1'b1 : ww[wd * 32 + (msb ? dl - b : b)];
      chk(u_far.data_q[i0 + 4 + k], e);
    end
  endtask

  initial begin
    logic [31:0] s;
    awaddr = 6'h0;
    araddr = 6'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    run = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(OFS_FMR, s, RESP_OKAY);
    chk(s, FMR_RST);
    rd(OFS_SR, s, RESP_OKAY);
    chk(s, 32'h0000_0003);
    for (int i = 0; i < 3; i++) begin
      rd(regs[i], s, RESP_OKAY);
      chk(s, 32'h0);
      wr(regs[i], 32'hffff_ffff, RESP_OKAY);
      rd(regs[i], s, RESP_OKAY);
      chk(s, 32'h0000_ffff);
    end
    rd(OFS_RSH, s, RESP_OKAY);
    chk(s, 32'h0);
    rd(OFS_THR, s, RESP_OKAY);
    chk(s, 32'h0);
    wr(6'h24, 32'h1, RESP_SLVERR);
    rd(6'h3c, s, RESP_SLVERR);
    chk(s, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_FMR, {27'h0, lens[i]}, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk(dma_size, lens[i] <= 7 ? DMA_BYTE : lens[i] <= 15 ? DMA_HALF : DMA_WORD);
    end
    for (int i = 0; i < 8; i++) begin
      wr(OFS_FMR, {9'h0, i[2:0], 15'h0, 5'h07}, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk(fs_oe, i >= 1 && i <= 5);
    end
    for (int v = 0; v < 2; v++) begin
      wr(OFS_FMR, {26'h0, v[0], 5'h07}, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk(sd, v[0]);
      wr(OFS_CTL, 32'h4, RESP_OKAY);
      repeat (2) @(posedge clock);
      chk(sd_oe, v[0]);
      wr(OFS_CTL, 32'h3, RESP_OKAY);
    end
    // Compare zero matches the four sync bits that the receiver collects.
    wr(OFS_CP0, 32'h0000_000a, RESP_OKAY);
    frame(5'h07, 1'b0, 3'h2, 1'b1, 1'b0);
    frame(5'h0f, 1'b1, 3'h1, 1'b0, 1'b1);
    frame(5'h01, 1'b1, 3'h2, 1'b1, 1'b0);
    tally_and_finish();
  end
endmodule // tb_sync_serial_tx_framing_and_data

`default_nettype wire
